// File: src/twe_pkg.sv
// Constants and types for the two-wire serial memory bus target.
// Assumes a 250 MHz system clock that samples both bus lines as plain inputs.
package twe_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int NVW_TIME_MS = 10;
  localparam int NVW_FAST_TIME_MS = 5;
  localparam int NVW_CYCLES = NVW_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int NVW_FAST_CYCLES = NVW_FAST_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int NVW_CNT_W = 22;

  localparam int WORD_W = 8;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [4:0] DEV_TYPE_CODE = 5'h14;
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 3;
  localparam int ADDR_CS1_POS = 2;
  localparam int ADDR_CS0_POS = 1;
  localparam int ADDR_DIR_POS = 0;

  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;

  localparam int SYNC_W = 5;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_CS0 = 2;
  localparam int SYNC_CS1 = 3;
  localparam int SYNC_FAST = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h2,
    ST_WRX = 3'h3,
    ST_RTX = 3'h4,
    ST_RACK = 3'h5,
    ST_WAIT = 3'h6
  } twe_state_type;

endpackage : twe_pkg

// File: src/twe_sync2.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes each bit is a slow level; only the second flop is read outside.
`timescale 1ns/1ns
module twe_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : twe_sync2

// File: src/twe_fifo2.sv
// Small valid/ready buffer, flop storage addressed by index.
// Assumes both sides run on the same clock.
`timescale 1ns/1ns
module twe_fifo2
  import twe_pkg::*;
#(
  parameter int WIDTH = BUF_WIDTH,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_next

  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ptr_next(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_next(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : twe_fifo2

// File: src/twe_slave.sv
// Bus target of a two-wire serial memory: framing, addressing, acknowledge,
// byte transfer and the self-timed nonvolatile write.
// Assumes an external pull-up on the data line and a controller-driven clock.
`timescale 1ns/1ns
module twe_slave
  import twe_pkg::*;
#(
  parameter int NVW_SLOW = NVW_CYCLES,
  parameter int NVW_FAST = NVW_FAST_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_bit0_pin_i,
  input wire logic chip_select_bit1_pin_i,
  input wire logic fast_revision_i,
  output logic [WORD_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [WORD_W-1:0] tx_data_i,
  output logic tx_take_o,
  output logic nvw_busy_o,
  output logic standby_o
);

  logic [SYNC_W-1:0] sync_s;
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  twe_state_type state_q;
  logic [3:0] bit_cnt_q;
  logic [WORD_W-1:0] shift_q;
  logic dir_read_q;
  logic got_data_q;
  logic master_ack_q;
  logic sda_oe_q;
  logic busy_q;
  logic [NVW_CNT_W-1:0] busy_cnt_q;
  logic addr_match;
  logic word_done;
  logic push_valid;
  logic push_ready;
  logic nvw_launch;

  twe_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({fast_revision_i, chip_select_bit1_pin_i, chip_select_bit0_pin_i, sda_i, scl_i}),
    .sync_o(sync_s)
  );

  assign scl_s = sync_s[SYNC_SCL];
  assign sda_s = sync_s[SYNC_SDA];

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  // Both lines pass the same synchroniser depth, so their order is kept.
  assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_ev = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // A busy part refuses its address so that the controller can poll it.
  assign addr_match = (shift_q[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE_CODE)
    && (shift_q[ADDR_CS1_POS] == sync_s[SYNC_CS1])
    && (shift_q[ADDR_CS0_POS] == sync_s[SYNC_CS0])
    && !busy_q;
  assign word_done = scl_fall && (bit_cnt_q == BITS_PER_WORD);
  // A full buffer withholds the acknowledge; the word is dropped and the target waits for a start or stop.
  assign push_valid = (state_q == ST_WRX) && word_done && !start_ev && !stop_ev;
  assign nvw_launch = stop_ev && !dir_read_q && got_data_q;

  twe_fifo2 #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(shift_q),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      dir_read_q <= 1'b0;
      got_data_q <= 1'b0;
      master_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      tx_take_o <= 1'b0;
    end else begin
      tx_take_o <= 1'b0;
      if (start_ev) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        got_data_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        // A stray second stop without a start must not launch another write cycle.
        got_data_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WRX: begin
            if (scl_rise && bit_cnt_q != BITS_PER_WORD) begin
              shift_q <= {shift_q[WORD_W-2:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (word_done) begin
              if (state_q == ST_ADDR) begin
                if (addr_match) begin
                  state_q <= ST_ACK;
                  sda_oe_q <= 1'b1;
                  dir_read_q <= shift_q[ADDR_DIR_POS];
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (push_ready) begin
                state_q <= ST_ACK;
                sda_oe_q <= 1'b1;
                got_data_q <= 1'b1;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (dir_read_q) begin
                state_q <= ST_RTX;
                shift_q <= tx_data_i;
                tx_take_o <= 1'b1;
                sda_oe_q <= !tx_data_i[WORD_W-1];
              end else begin
                state_q <= ST_WRX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          ST_RTX: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (word_done) begin
              state_q <= ST_RACK;
              sda_oe_q <= 1'b0;
            end else if (scl_fall) begin
              shift_q <= {shift_q[WORD_W-2:0], 1'b0};
              sda_oe_q <= !shift_q[WORD_W-2];
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack_q <= !sda_s;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (master_ack_q) begin
                state_q <= ST_RTX;
                shift_q <= tx_data_i;
                tx_take_o <= 1'b1;
                sda_oe_q <= !tx_data_i[WORD_W-1];
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (nvw_launch && !busy_q) begin
      busy_q <= 1'b1;
      busy_cnt_q <= sync_s[SYNC_FAST] ? NVW_CNT_W'(NVW_FAST) : NVW_CNT_W'(NVW_SLOW);
    end else if (busy_q) begin
      if (busy_cnt_q <= NVW_CNT_W'(1)) begin
        busy_q <= 1'b0;
        busy_cnt_q <= '0;
      end else begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
      end
    end
  end

  // The line is only ever pulled low; the pull-up makes every high level.
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;
  assign nvw_busy_o = busy_q;
  assign standby_o = (state_q == ST_IDLE) && !busy_q;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  property never_high_p;
    sda_oe_o |-> (sda_o == 1'b0);
  endproperty

  pull_low_only_a: assert property (never_high_p)
    else $error("Data line driven high.");

  drive_on_low_a: assert property ($rose(sda_oe_o) |-> !scl_s)
    else $error("Data line pulled low while the clock is high.");

  start_restart_a: assert property (start_ev |=> (state_q == ST_ADDR) && (bit_cnt_q == 4'h0)
    && !sda_oe_o)
    else $error("Start did not restart address reception.");

  stop_ends_a: assert property (stop_ev |=> (state_q == ST_IDLE) && !sda_oe_o)
    else $error("Stop did not end the transaction.");

  read_stop_standby_a: assert property ((stop_ev && dir_read_q && !busy_q) |=> standby_o)
    else $error("No standby right after a read stop.");

  ack_ninth_a: assert property ((state_q == ST_ACK) && scl_rise |-> sda_oe_o
    ##1 (sda_oe_o || start_ev || stop_ev))
    else $error("Acknowledge not held over the ninth clock.");

  mismatch_release_a: assert property ((state_q == ST_ADDR) && word_done && !start_ev
    && !stop_ev && !addr_match |=> (state_q == ST_IDLE) && !sda_oe_o)
    else $error("Unmatched address was acknowledged.");

  busy_refuse_a: assert property (busy_q && (state_q == ST_ADDR) && word_done
    |=> !sda_oe_o && (state_q == ST_IDLE))
    else $error("Address accepted during the nonvolatile write.");

  nvw_launch_a: assert property ((nvw_launch && !busy_q) |=> busy_q [*8])
    else $error("Nonvolatile write did not start or ended early.");

  nvw_bound_a: assert property (busy_cnt_q <= NVW_CNT_W'(NVW_SLOW))
    else $error("Write cycle counter beyond its longest time.");

  standby_rule_a: assert property (stop_ev && !nvw_launch && !busy_q |=> standby_o)
    else $error("No standby after a stop with nothing pending.");

  read_dir_a: assert property ((state_q == ST_ACK) && scl_fall && dir_read_q && !start_ev
    && !stop_ev |=> (state_q == ST_RTX) && tx_take_o)
    else $error("Read direction did not start transmission.");

  steady_high_a: assert property (scl_s && scl_prev_q && !start_ev && !stop_ev
    |=> $stable(sda_oe_o))
    else $error("Data line pull changed while the clock was high.");

  idle_ignore_a: assert property ((state_q == ST_IDLE) && !start_ev
    |=> (state_q == ST_IDLE) && !sda_oe_o)
    else $error("Bus activity without a start was answered.");

  fast_time_a: assert property (nvw_launch && !busy_q && sync_s[SYNC_FAST]
    |=> busy_cnt_q == NVW_CNT_W'(NVW_FAST))
    else $error("Fast revision did not select the short write time.");

  addr_cs_a: assert property ((state_q == ST_ADDR) && word_done
    && (shift_q[ADDR_CS0_POS] != sync_s[SYNC_CS0]) |=> !sda_oe_o && (state_q == ST_IDLE))
    else $error("Address with other chip-select bits was acknowledged.");

  full_nack_a: assert property ((state_q == ST_WRX) && word_done && !push_ready
    |=> (state_q == ST_WAIT) && !sda_oe_o)
    else $error("Word acknowledged while the buffer was full.");

  write_ack_c: cover property ((state_q == ST_WRX) ##[1:400] (state_q == ST_ACK));
  read_byte_c: cover property ((state_q == ST_RTX) ##[1:400] (state_q == ST_RACK));
  mismatch_c: cover property ((state_q == ST_ADDR) && word_done && !addr_match);
  nvw_done_c: cover property ($fell(busy_q));
  poll_refused_c: cover property (busy_q && (state_q == ST_ADDR) && word_done);

endmodule : twe_slave

// File: tb/twe_ctrl_model.sv
// Bus controller model that drives the serial clock and pulls the data line.
// Assumes an external pull-up: the bench resolves the wire from every pull.
`timescale 1ns/1ns
module twe_ctrl_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One 125 ns clock slot; the clock idles high between frames.
  task automatic bit_slot(input logic b, output logic seen);
    scl_o = 1'b0;
    #31 sda_low_o = !b;
    #32 scl_o = 1'b1;
    #31 seen = sda_i;
    #31;
  endtask : bit_slot
  task automatic start;
    scl_o = 1'b0;
    #31 sda_low_o = 1'b0;
    #32 scl_o = 1'b1;
    #31 sda_low_o = 1'b1;
    #31;
  endtask : start
  task automatic stop;
    scl_o = 1'b0;
    #31 sda_low_o = 1'b1;
    #32 scl_o = 1'b1;
    #31 sda_low_o = 1'b0;
    #31;
  endtask : stop
  task automatic send(input logic [7:0] w, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(w[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] w);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, w[i]);
    bit_slot(!ack, s);
  endtask : recv
  // Nine released clocks; reports whether the line was high in every one.
  task automatic recover(output logic all_high);
    logic s;
    all_high = 1'b1;
    for (int i = 0; i < 9; i++) begin
      bit_slot(1'b1, s);
      all_high = all_high & s;
    end
  endtask : recover
endmodule : twe_ctrl_model

// File: tb/tb_top.sv
// Self-checking bench for the two-wire memory bus target.
// Assumes shortened write-cycle counts; the wire is pulled up when released.
`timescale 1ns/1ns
module tb_top;
  import twe_pkg::*;
  localparam int SLOW = 2000;
  localparam int FAST = 1000;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda, sda_o, sda_oe, cs0 = 1'b0, cs1 = 1'b1, fast = 1'b0;
  logic rx_valid, rx_ready = 1'b0, tx_take, busy, standby, ack, hi;
  logic [7:0] rx_data, tx_data = 8'h00, w;
  int error_cnt = 0;
  int tests_run = 0;
  int busy_cycles = 0;
  int take_cnt = 0;
  assign sda = !(sda_oe || sda_low);
  always #2 clock = ~clock;
  twe_ctrl_model i_ctrl (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  twe_slave #(.NVW_SLOW(SLOW), .NVW_FAST(FAST)) i_dut (
    .clock_i(clock), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .chip_select_bit0_pin_i(cs0), .chip_select_bit1_pin_i(cs1),
    .fast_revision_i(fast), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_take_o(tx_take),
    .nvw_busy_o(busy), .standby_o(standby));
  always @(posedge clock) begin
    if (busy === 1'b1) busy_cycles++;
    if (tx_take === 1'b1) take_cnt++;
    if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
      error_cnt++;
      $display("BAD sda_o expected 0 seen %b", sda_o);
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // Waits out a write cycle and judges its length in system clocks.
  task automatic wait_write(input int len);
    for (int k = 0; k < 3 * SLOW && busy !== 1'b0; k++) @(negedge clock);
    repeat (2) @(negedge clock);
    chk("busy end", 8'h00, {7'h00, busy});
    chk("standby", 8'h01, {7'h00, standby});
    chk("busy len", 8'h01, {7'h00, busy_cycles >= len - 3 && busy_cycles <= len + 3});
  endtask : wait_write
  task automatic t_write;
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    chk("addr ack", 8'h01, {7'h00, ack});
    i_ctrl.send(8'h5A, ack);
    chk("data ack", 8'h01, {7'h00, ack});
    chk("rx valid", 8'h01, {7'h00, rx_valid});
    chk("rx data", 8'h5A, rx_data);
    @(negedge clock) rx_ready = 1'b1;
    @(negedge clock) rx_ready = 1'b0;
    busy_cycles = 0;
    i_ctrl.stop();
    repeat (8) @(negedge clock);
    chk("busy", 8'h01, {7'h00, busy});
    chk("no standby", 8'h00, {7'h00, standby});
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    chk("poll ack", 8'h00, {7'h00, ack});
    i_ctrl.stop();
    wait_write(SLOW);
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    chk("poll done", 8'h01, {7'h00, ack});
    i_ctrl.stop();
    $display("test write done");
  endtask : t_write
  task automatic t_mismatch;
    i_ctrl.start();
    i_ctrl.send(8'hA2, ack);
    chk("wrong cs", 8'h00, {7'h00, ack});
    i_ctrl.send(8'hFF, ack);
    chk("ignored", 8'h00, {7'h00, ack || rx_valid});
    i_ctrl.stop();
    chk("idle", 8'h01, {7'h00, standby});
    $display("test mismatch done");
  endtask : t_mismatch
  task automatic t_read;
    @(negedge clock) tx_data = 8'hC3;
    take_cnt = 0;
    i_ctrl.start();
    i_ctrl.send(8'hA5, ack);
    chk("read ack", 8'h01, {7'h00, ack});
    i_ctrl.recv(1'b0, w);
    chk("read data", 8'hC3, w);
    i_ctrl.stop();
    repeat (8) @(negedge clock);
    chk("one take", 8'h01, take_cnt[7:0]);
    chk("standby", 8'h01, {7'h00, standby && !busy});
    $display("test read done");
  endtask : t_read
  task automatic t_framing;
    i_ctrl.start();
    for (int i = 0; i < 4; i++) i_ctrl.bit_slot(1'b0, hi);
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    chk("restart", 8'h01, {7'h00, ack});
    for (int i = 0; i < 3; i++) i_ctrl.bit_slot(1'b1, hi);
    i_ctrl.stop();
    repeat (8) @(negedge clock);
    chk("cut word", 8'h00, {7'h00, rx_valid || busy});
    i_ctrl.send(8'hA4, ack);
    chk("no start", 8'h00, {7'h00, ack});
    i_ctrl.recover(hi);
    chk("free line", 8'h01, {7'h00, hi});
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    chk("recovered", 8'h01, {7'h00, ack});
    i_ctrl.stop();
    $display("test framing done");
  endtask : t_framing
  task automatic t_buffer;
    @(negedge clock) fast = 1'b1;
    i_ctrl.start();
    i_ctrl.send(8'hA4, ack);
    i_ctrl.send(8'h11, ack);
    i_ctrl.send(8'h22, hi);
    chk("two acks", 8'h01, {7'h00, ack && hi});
    i_ctrl.send(8'h33, ack);
    chk("full", 8'h00, {7'h00, ack});
    busy_cycles = 0;
    i_ctrl.stop();
    chk("first", 8'h11, rx_data);
    @(negedge clock) rx_ready = 1'b1;
    @(negedge clock) rx_ready = 1'b0;
    chk("second", 8'h22, rx_data);
    @(negedge clock) rx_ready = 1'b1;
    @(negedge clock) rx_ready = 1'b0;
    chk("empty", 8'h00, {7'h00, rx_valid});
    wait_write(FAST);
    $display("test buffer done");
  endtask : t_buffer
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk("standby reset", 8'h01, {7'h00, standby && !busy && !sda_oe});
    t_write();
    t_mismatch();
    t_read();
    t_framing();
    t_buffer();
    end_of_test();
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
